// File: wdg_timer.sv
// wdg_timer: watchdog timer with guarded turn-off, reached over a classic
// wishbone slave; counts edges of a separate watchdog oscillator.
// assumes a single system clock and a restart pulse from the core.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RULE1 - the counter advances on cycles of its own oscillator, not the system clock.
// RULE2 - the restart instruction clears the counter and starts a new period.
// RULE3 - when the period elapses without restart a system reset is requested.
// RULE4 - the 3-bit period select picks 16K doubling up to 2,048K oscillator cycles.
// RULE5 - control bit 3 enables the watchdog while one and disables it while zero.
// RULE6 - clearing the enable bit works only while the unlock bit is one.
// RULE7 - the unlock bit clears itself four system cycles after being set.
// RULE8 - software sets unlock and enable together, then clears enable in four cycles.
// RULE9 - control bits 7 to 5 are reserved and read as zero.
// RULE10 - software should restart the counter before enabling the watchdog.
// RULE11 - restart and time-out are passed safely between the two timing sources; here only the oscillator level is synchronized, both stay on i_clk_sys.
module wdg_timer
#(
   parameter int BASE_LOG2 = wdg_pkg::BASE_LOG2
)
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_resetn,
   input  wire logic        i_wdt_osc,
   input  wire logic        i_watchdog_restart_instruction,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic             o_wb_ack,
   output logic [31:0]      o_wb_dat,
   output logic             o_system_reset
);
   localparam int CW = wdg_pkg::COUNT_WIDTH;
   // last live cycle of the unlock window and the steps of both counters
   localparam logic [2:0]    WIN_LAST = 3'h1;
   localparam logic [2:0]    WIN_STEP = 3'h1;
   localparam logic [CW-1:0] CNT_STEP = {{(CW-1){1'b0}}, 1'b1};

   logic          osc_tick;
   logic          ack_reg;
   logic          ack_next;
   logic [31:0]   rdat_reg;
   logic [31:0]   rdat_next;
   logic [2:0]    period_reg;
   logic [2:0]    period_next;
   logic          enable_reg;
   logic          enable_next;
   logic          unlock_reg;
   logic          unlock_next;
   logic [2:0]    unlock_cnt_reg;
   logic [2:0]    unlock_cnt_next;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic          rst_reg;
   logic          rst_next;
   logic          wr_ctrl;
   logic          expire;

   // last count value before time-out for a period code
   // counter is sized for the longest period, so the shift cannot overflow
   function automatic logic [CW-1:0] last_count(input logic [2:0] code);
      logic [CW-1:0] one;
      one = {{(CW-1){1'b0}}, 1'b1};
      last_count = (one << (BASE_LOG2 + int'(code))) - one;   // RULE4
   endfunction : last_count

   // control register image as software reads it
   // reserved bits stay zero because the image starts from an all-zero word
   function automatic logic [31:0] ctrl_image(input logic [2:0] per,
                                              input logic en,
                                              input logic unl);
      logic [31:0] v;
      v = 32'h0;                                     // RULE9
      v[wdg_pkg::PERIOD_MSB:wdg_pkg::PERIOD_LSB] = per;
      v[wdg_pkg::ENABLE_BIT] = en;
      v[wdg_pkg::UNLOCK_BIT] = unl;
      ctrl_image = v;
   endfunction : ctrl_image

   // oscillator level crosses into the system domain here
   // the edge stage adds three system cycles of latency to every tick
   wdg_osc_edge u_osc_edge
   (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .i_osc     (i_wdt_osc),
      .o_tick    (osc_tick)
   );

   // wishbone slave: ack one cycle after request, dropped the cycle after;
   // writes land on the edge the master samples ack, so no early effect
   // unmapped offsets still answer so a stray access cannot hang the core
   always_comb
   begin
      ack_next  = i_wb_cyc & i_wb_stb & ~ack_reg;
      rdat_next = rdat_reg;
      if (i_wb_cyc && i_wb_stb && !ack_reg)
      begin
         unique case (i_wb_adr)
            wdg_pkg::ADR_CONTROL:
               rdat_next = ctrl_image(period_reg, enable_reg, unlock_reg);
            wdg_pkg::ADR_COUNT:
               rdat_next = {{(32-CW){1'b0}}, count_reg};
            default:
               rdat_next = 32'h0;                    // unmapped reads zero
         endcase
      end
      wr_ctrl = ack_reg & i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0]
                & (i_wb_adr == wdg_pkg::ADR_CONTROL);
   end

   // ack and read data clear on reset so no stale word is seen
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0;
      end
      else
      begin
         ack_reg  <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   // control bits and the unlock window
   // a write landing in the window's last cycle still clears enable
   always_comb
   begin
      period_next     = period_reg;
      enable_next     = enable_reg;
      unlock_next     = unlock_reg;
      unlock_cnt_next = unlock_cnt_reg;
      // window runs down; last cycle drops the unlock bit
      if (unlock_reg)
      begin
         if (unlock_cnt_reg == WIN_LAST)
            unlock_next = 1'b0;                      // RULE7
         unlock_cnt_next = unlock_cnt_reg - WIN_STEP;
      end
      if (wr_ctrl)
      begin
         period_next = i_wb_dat[wdg_pkg::PERIOD_MSB:wdg_pkg::PERIOD_LSB];
         // setting enable always works; clearing needs an open window
         if (i_wb_dat[wdg_pkg::ENABLE_BIT])
            enable_next = 1'b1;                      // RULE5
         else if (unlock_reg)
            enable_next = 1'b0;                      // RULE6
         // a write setting unlock together with enable opens the window
         if (i_wb_dat[wdg_pkg::UNLOCK_BIT] && i_wb_dat[wdg_pkg::ENABLE_BIT])
         begin
            unlock_next     = 1'b1;                  // RULE8
            unlock_cnt_next = wdg_pkg::UNLOCK_CYCLES;
         end
      end
   end

   // reset leaves the watchdog off with the window shut
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         period_reg     <= wdg_pkg::PERIOD_RESET;
         enable_reg     <= wdg_pkg::ENABLE_RESET;
         unlock_reg     <= 1'b0;
         unlock_cnt_reg <= 3'h0;
      end
      else
      begin
         period_reg     <= period_next;
         enable_reg     <= enable_next;
         unlock_reg     <= unlock_next;
         unlock_cnt_reg <= unlock_cnt_next;
      end
   end

   // counter: frozen while disabled and not cleared, so enabling without
   // a restart resumes from a stale value
   // restart is tested first so a kick in the expiry cycle always wins
   always_comb
   begin
      expire     = enable_reg & osc_tick & (count_reg >= last_count(period_reg));
      count_next = count_reg;
      rst_next   = 1'b0;
      if (i_watchdog_restart_instruction)
         count_next = '0;                            // RULE2
      else if (expire)
      begin
         count_next = '0;
         rst_next   = 1'b1;                          // RULE3
      end
      else if (enable_reg && osc_tick)
         count_next = count_reg + CNT_STEP;          // RULE1
   end

   // count and reset pulse clear on reset; the pulse never starts high
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         count_reg <= '0;
         rst_reg   <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         rst_reg   <= rst_next;
      end
   end

   // outputs are taken straight from flip-flops
   assign o_wb_ack       = ack_reg;
   assign o_wb_dat       = rdat_reg;
   assign o_system_reset = rst_reg;
endmodule : wdg_timer
`default_nettype wire

// File: wdg_pkg.sv
// wdg_pkg: register map, field positions and timing constants of the
// watchdog timer; shared by the timer top, its checker and its testbench.
package wdg_pkg;
   // register byte addresses on the wishbone slave
   localparam logic [7:0]  ADR_CONTROL    = 8'h00;
   localparam logic [7:0]  ADR_COUNT      = 8'h04;
   // watchdog_control field positions
   localparam int          PERIOD_LSB     = 0;
   localparam int          PERIOD_MSB     = 2;
   localparam int          ENABLE_BIT     = 3;
   localparam int          UNLOCK_BIT     = 4;
   localparam int          CTRL_WIDTH     = 8;
   // reset values
   localparam logic [2:0]  PERIOD_RESET   = 3'h0;
   localparam logic        ENABLE_RESET   = 1'b0;
   // unlock window length in system clock cycles
   localparam logic [2:0]  UNLOCK_CYCLES  = 3'h4;
   // oscillator cycle count: 16K at code 000, doubling per code
   localparam int          BASE_LOG2      = 14;
   localparam int          COUNT_WIDTH    = 22;
endpackage : wdg_pkg

// File: wdg_osc_edge.sv
// wdg_osc_edge: brings the free-running watchdog oscillator level into
// the system clock domain and emits one pulse per rising oscillator edge.
// assumes the oscillator runs well below half the system clock rate.
`timescale 1ns/1ns
`default_nettype none
module wdg_osc_edge
(
   input  wire logic i_clk_sys,
   input  wire logic i_resetn,
   input  wire logic i_osc,
   output logic      o_tick
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic       tick_reg;
   logic       tick_next;

   // stage 0 is only read by stage 1; edge taken from stages 1 and 2
   always_comb
   begin
      sync_next = {sync_reg[1:0], i_osc};           // RULE11
      tick_next = sync_reg[1] & ~sync_reg[2];       // RULE1
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sync_reg <= 3'h0;
         tick_reg <= 1'b0;
      end
      else
      begin
         sync_reg <= sync_next;
         tick_reg <= tick_next;
      end
   end

   assign o_tick = tick_reg;
endmodule : wdg_osc_edge
`default_nettype wire

// File: wdg_timer_props.sv
// wdg_timer_props: port-level checks of the watchdog timer
// assumes an oscillator half period of 6 system cycles; bound to wdg_timer
`timescale 1ns/1ns
`default_nettype none
module wdg_timer_props
(
   input wire logic        i_clk_sys,
   input wire logic        i_resetn,
   input wire logic        i_wdt_osc,
   input wire logic        i_watchdog_restart_instruction,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic [7:0]  i_wb_adr,
   input wire logic        o_wb_ack,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_system_reset
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   // bus answer one cycle after the request, then dropped
   property p_ack; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_ack1; o_wb_ack |=> !o_wb_ack; endproperty
   a_ack1: assert property (p_ack1) else $error("ack too long");
   property p_hold; !(i_wb_cyc && i_wb_stb) |=> $stable(o_wb_dat); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_rsv; o_wb_ack && i_wb_adr == wdg_pkg::ADR_CONTROL
      |-> o_wb_dat[31:5] == 27'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_cnt; o_wb_ack && i_wb_adr == wdg_pkg::ADR_COUNT
      |-> o_wb_dat[31:22] == 10'h0; endproperty
   a_cnt: assert property (p_cnt) else $error("count too wide");
   property p_unm; o_wb_ack && i_wb_adr == 8'h08 |-> o_wb_dat == 32'h0;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_pulse; o_system_reset |=> !o_system_reset; endproperty
   a_pulse: assert property (p_pulse) else $error("reset too long");
   // a fresh period cannot end within a few cycles of a restart
   property p_kick; i_watchdog_restart_instruction |=> !o_system_reset[*8];
   endproperty
   a_kick: assert property (p_kick) else $error("reset after restart");
   // expiry follows a rising oscillator edge by a few cycles only
   property p_osc; o_system_reset |-> i_wdt_osc && !$past(i_wdt_osc, 6);
   endproperty
   a_osc: assert property (p_osc) else $error("reset off osc edge");
endmodule : wdg_timer_props
bind wdg_timer wdg_timer_props i_props (.i_clk_sys, .i_resetn, .i_wdt_osc,
   .i_watchdog_restart_instruction, .i_wb_cyc, .i_wb_stb, .i_wb_adr,
   .o_wb_ack, .o_wb_dat, .o_system_reset);
`default_nettype wire

// File: tb_wdg_timer.sv
// tb_wdg_timer: register-level tests of the watchdog timer
// assumes the checker is bound in; shortened periods via BASE_LOG2
`timescale 1ns/1ns
`default_nettype none
module tb_wdg_timer;
   localparam int           BL = 2;
   localparam logic [7:0]   CT = wdg_pkg::ADR_CONTROL;
   logic        clk = 1'b0, rstn = 1'b0, osc = 1'b0, watchdog_restart_instruction = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, sreset;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   int          error_cnt = 0, check_count = 0, rst_cnt = 0, n;
   always #2 clk = ~clk;
   // free running, 12 system cycles; toggles on falling clock edges
   always #24 osc = ~osc;
   always @(posedge clk) if (sreset === 1'b1) rst_cnt <= rst_cnt + 1;
   wdg_timer #(.BASE_LOG2(BL)) i_dut (.i_clk_sys(clk), .i_resetn(rstn),
      .i_wdt_osc(osc), .i_watchdog_restart_instruction(watchdog_restart_instruction),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
      .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
      .o_system_reset(sreset));
   task automatic tally_and_finish(input bit hung);
      error_cnt += hung;
      $display("checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // one classic cycle; read data taken at the edge that sees ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge clk);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
      t = 0;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (ack !== 1'b1 && t < 50);
      q = rdat;
      {cyc, stb} <= 2'b00;
      if (ack !== 1'b1) tally_and_finish(1'b1);
   endtask : wb
   task automatic kick();
      @(posedge clk);
      watchdog_restart_instruction <= 1'b1;
      @(posedge clk);
      watchdog_restart_instruction <= 1'b0;
   endtask : kick
   // time from restart to expiry, 2^(BL+p) oscillator cycles of 12
   task automatic tmo(input logic [2:0] p);
      int k;
      kick();
      wb(1'b1, CT, {29'h0, p} | 32'h8);
      kick();
      k = 0;
      while (sreset !== 1'b1 && k < 4000)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 4000) tally_and_finish(1'b1);
      n = (1 << (BL + p)) * 12;
      chk(32'(k > n - 16 && k < n + 16), 32'h1);
   endtask : tmo
   initial
   begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      wb(1'b0, CT, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, 8'h08, 32'h0);
      chk(q, 32'h0);
      $display("test reset values done");
      wb(1'b1, CT, 32'hef);
      wb(1'b0, CT, 32'h0);
      chk(q, 32'h0f);
      wb(1'b1, CT, 32'h00);
      wb(1'b0, CT, 32'h0);
      chk(q, 32'h08);
      wb(1'b1, CT, 32'h10);
      wb(1'b0, CT, 32'h0);
      chk(q, 32'h08);
      wb(1'b1, CT, 32'h18);
      wb(1'b0, CT, 32'h0);
      chk(q, 32'h18);
      repeat (6) @(posedge clk);
      wb(1'b0, CT, 32'h0);
      chk(q, 32'h08);
      // late clear after the window closed must be refused
      wb(1'b1, CT, 32'h18);
      repeat (6) @(posedge clk);
      wb(1'b1, CT, 32'h00);
      wb(1'b0, CT, 32'h0);
      chk(q, 32'h08);
      wb(1'b1, CT, 32'h18);
      wb(1'b1, CT, 32'h00);
      wb(1'b0, CT, 32'h0);
      chk(q, 32'h00);
      $display("test turn-off sequence done");
      for (int p = 0; p < 3; p++) tmo(3'(p));
      $display("test time-out periods done");
      kick();
      wb(1'b1, CT, 32'h08);
      n = rst_cnt;
      repeat (20)
      begin
         repeat (24) @(posedge clk);
         kick();
      end
      chk(32'(rst_cnt), 32'(n));
      wb(1'b1, CT, 32'h18);
      wb(1'b1, CT, 32'h00);
      kick();
      wb(1'b0, wdg_pkg::ADR_COUNT, 32'h0);
      chk(q, 32'h0);
      n = rst_cnt;
      repeat (300) @(posedge clk);
      chk(32'(rst_cnt), 32'(n));
      wb(1'b0, wdg_pkg::ADR_COUNT, 32'h0);
      chk(q, 32'h0);
      $display("test restart and disable done");
      tally_and_finish(1'b0);
   end
endmodule : tb_wdg_timer
`default_nettype wire
